// [core/tone_report_pkg.sv]
/*
  Shared constants for the tone report block: register map, field
  positions, default tone tables.
  Assumes a 32-bit Avalon-MM byte address space of 256 bytes.
*/
package tone_report_pkg;
  // ==========================================================
  // Sizes
  localparam int FREQ_W = 12;
  localparam int CODE_W = 4;
  localparam int NCODES = 16;
  localparam int ADDR_W = 8;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_TONE = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_TXTONE = 8'h0c;
  localparam logic [7:0] OFS_SLOT_BASE = 8'h40;
  // Slot n sits at OFS_SLOT_BASE + 4*n; codes use slots first..last
  localparam logic [5:0] TONE_SLOT_FIRST = 6'h02;
  localparam logic [5:0] TONE_SLOT_LAST = 6'h11;
  // ==========================================================
  // Field positions
  localparam int ST_INBAND_BIT = 13;
  localparam int ST_DTMF_BIT = 12;
  localparam int TS_SEL_BIT = 15;
  localparam int TS_CODE_LSB = 11;
  localparam int TS_DTMF_BIT = 10;
  localparam int TX_SEL_LSB = 11;
  localparam int TX_DTMF_LSB = 0;
  localparam int TX_GEN_BIT = 4;
  localparam int TX_SINGLE_BIT = 5;
  localparam int MODE_SEL_BIT = 0;
  localparam int MODE_DTMF_BIT = 1;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] TX_RESET = 16'h0000;
  localparam logic [3:0] REPEAT_CODE = 4'he;
  // ==========================================================
  // Default slot contents, entry 0 first from the right
  localparam logic [NCODES-1:0][FREQ_W-1:0] SEL_DEFAULT = {
    12'h41f, 12'h83e, 12'h3df, 12'h8c7, 12'h3a2, 12'h960, 12'h744, 12'h6d3,
    12'h668, 12'h604, 12'h5a6, 12'h54e, 12'h4fb, 12'h4ad, 12'h464, 12'h7bd};
  // DTMF low and high tone per code 0..f
  localparam logic [NCODES-1:0][FREQ_W-1:0] DTMF_LO = {
    12'h354, 12'h302, 12'h2b9, 12'h3ad, 12'h3ad, 12'h3ad, 12'h354, 12'h354,
    12'h354, 12'h302, 12'h302, 12'h302, 12'h2b9, 12'h2b9, 12'h2b9, 12'h3ad};
  localparam logic [NCODES-1:0][FREQ_W-1:0] DTMF_HI = {
    12'h661, 12'h661, 12'h661, 12'h5c5, 12'h4b9, 12'h538, 12'h5c5, 12'h538,
    12'h4b9, 12'h5c5, 12'h538, 12'h4b9, 12'h5c5, 12'h538, 12'h4b9, 12'h661};
  // Single tone keeps the high tone where the bit is set
  localparam logic [15:0] DTMF_SINGLE_HI = 16'hff00;
endpackage : tone_report_pkg

// [core/tone_slot_mem.sv]
/*
  Programmable tone slot memory, one write port and one read port.
  Read data are registered: address in one cycle, data the next.
*/
`timescale 1ns/100ps
module tone_slot_mem
  import tone_report_pkg::*;
#(
  parameter int DEPTH = NCODES,
  parameter int W = FREQ_W,
  parameter logic [DEPTH-1:0][W-1:0] INIT = SEL_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } mem_state_t;
  mem_state_t state_ff;
  mem_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = state_ff.mem[rd_addr];
    if (wr_en) begin
      nxt_state.mem[wr_addr] = wr_data;
    end
  end

  // Reset loads the standard set so no slot writes are needed before decoding
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '{mem: INIT, rdata: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data = state_ff.rdata;
endmodule : tone_slot_mem

// [core/inband_tone_decode_report.sv]
/*
  Tone decode reporting: maps detector frequencies to codes, keeps the
  tone status and event bits, holds the Tx tone register, Avalon-MM slave.
  Assumes detector inputs come from logic on clk and hold a steady
  frequency while their valid is high.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module inband_tone_decode_report
  import tone_report_pkg::*;
#(
  parameter logic [FREQ_W-1:0] TOL_HZ = 12'h00a
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sel_tone_valid,
  input wire logic [FREQ_W-1:0] sel_tone_freq,
  input wire logic dtmf_tone_valid,
  input wire logic [FREQ_W-1:0] dtmf_low_freq,
  input wire logic [FREQ_W-1:0] dtmf_high_freq,
  output logic tone_irq,
  output logic [CODE_W-1:0] tx_sel_code,
  output logic [FREQ_W-1:0] tx_low_freq,
  output logic [FREQ_W-1:0] tx_high_freq
);
  // ==========================================================
  // Types and state
  typedef enum logic [2:0] {
    ST_IDLE, ST_SCAN_RD, ST_SCAN_CMP, ST_BUS_RD, ST_BUS_ACK
  } fsm_t;

  typedef struct packed {
    fsm_t fsm;
    logic [CODE_W-1:0] scan_idx;
    logic [FREQ_W-1:0] cand;
    logic seen;
    logic sel_on;
    logic [CODE_W-1:0] sel_code;
    logic dtmf_on;
    logic [CODE_W-1:0] dtmf_code;
    logic irq_inband;
    logic irq_dtmf;
    logic [15:0] tone_status;
    logic [15:0] mode;
    logic [15:0] tx;
    logic [31:0] rdata;
    logic [FREQ_W-1:0] tx_lo;
    logic [FREQ_W-1:0] tx_hi;
  } state_t;

  state_t state_ff;
  state_t nxt_state;
  logic [FREQ_W-1:0] mem_rdata;
  logic [CODE_W-1:0] mem_rd_addr;
  logic mem_wr;
  logic [FREQ_W-1:0] mem_wdata;
  logic [15:0] mem_merged;

  // ==========================================================
  // Functions
  function automatic logic near(input logic [FREQ_W-1:0] a, input logic [FREQ_W-1:0] b);
    near = (a >= b) ? ((a - b) <= TOL_HZ) : ((b - a) <= TOL_HZ);
  endfunction : near

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  function automatic logic is_slot(input logic [ADDR_W-1:0] a);
    logic [5:0] w;
    w = a[7:2] - OFS_SLOT_BASE[7:2];
    is_slot = (a[7:2] >= OFS_SLOT_BASE[7:2]) && (w >= TONE_SLOT_FIRST) && (w <= TONE_SLOT_LAST);
  endfunction : is_slot

  // Code n is stored at slot n+2
  function automatic logic [CODE_W-1:0] slot_code(input logic [ADDR_W-1:0] a);
    logic [5:0] w;
    w = a[7:2] - OFS_SLOT_BASE[7:2] - TONE_SLOT_FIRST;
    slot_code = w[CODE_W-1:0];
  endfunction : slot_code

  // First matching pair wins; table is fixed key layout
  function automatic logic [CODE_W:0] dtmf_lookup(input logic [FREQ_W-1:0] lo,
                                                  input logic [FREQ_W-1:0] hi);
    dtmf_lookup = '0;
    for (int i = NCODES - 1; i >= 0; i--) begin
      if (near(lo, DTMF_LO[i]) && near(hi, DTMF_HI[i])) begin
        dtmf_lookup = {1'b1, 4'(i)};
      end
    end
  endfunction : dtmf_lookup

  // ==========================================================
  // Slot memory
  tone_slot_mem #(
    .DEPTH(NCODES),
    .W(FREQ_W),
    .INIT(SEL_DEFAULT)
  ) u_slots (
    .clk(clk),
    .nrst(nrst),
    .wr_en(mem_wr),
    .wr_addr(slot_code(address)),
    .wr_data(mem_wdata),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rdata)
  );

  assign mem_rd_addr = (state_ff.fsm == ST_SCAN_RD) ? state_ff.scan_idx : slot_code(address);
  assign mem_wr = (state_ff.fsm == ST_BUS_ACK) && write && is_slot(address);
  assign mem_merged = merge16({4'h0, mem_rdata}, writedata, byteenable);
  assign mem_wdata = mem_merged[FREQ_W-1:0];

  // ==========================================================
  // Next state
  logic sel_en;
  logic dtmf_en;
  logic [CODE_W:0] dtmf_hit;
  logic [CODE_W-1:0] txc;
  logic ack;

  always_comb begin
    nxt_state = state_ff;
    // Detectors are enabled independently by mode bits 0 and 1; both can run together
    sel_en = state_ff.mode[MODE_SEL_BIT];
    dtmf_en = state_ff.mode[MODE_DTMF_BIT];
    dtmf_hit = dtmf_lookup(dtmf_low_freq, dtmf_high_freq);
    txc = state_ff.tx[TX_DTMF_LSB +: CODE_W];
    ack = (state_ff.fsm == ST_BUS_ACK);

    // Clears first so that a same-cycle event below wins
    if (ack && read && address == OFS_STATUS) begin
      // Only bits the host has seen are cleared, so an event landing
      // during the read is not lost
      if (state_ff.rdata[ST_INBAND_BIT]) begin
        nxt_state.irq_inband = 1'b0;
      end
      if (state_ff.rdata[ST_DTMF_BIT]) begin
        nxt_state.irq_dtmf = 1'b0;
      end
    end
    if (ack && write && address == OFS_MODE) begin
      nxt_state.mode = merge16(state_ff.mode, writedata, byteenable);
    end
    if (ack && write && address == OFS_TXTONE) begin
      nxt_state.tx = merge16(state_ff.tx, writedata, byteenable);
    end

    if (!(sel_en && sel_tone_valid)) begin
      nxt_state.seen = 1'b0;
    end

    unique case (state_ff.fsm)
      ST_IDLE: begin
        if (sel_en && sel_tone_valid && (!state_ff.seen || sel_tone_freq != state_ff.cand)) begin
          nxt_state.cand = sel_tone_freq;
          nxt_state.seen = 1'b1;
          nxt_state.scan_idx = '0;
          nxt_state.fsm = ST_SCAN_RD;
        end else if (read || write) begin
          nxt_state.fsm = ST_BUS_RD;
        end
      end
      ST_SCAN_RD: begin
        nxt_state.fsm = (sel_en && sel_tone_valid) ? ST_SCAN_CMP : ST_IDLE;
      end
      ST_SCAN_CMP: begin
        if (!(sel_en && sel_tone_valid)) begin
          nxt_state.fsm = ST_IDLE;
        end else if (near(state_ff.cand, mem_rdata)) begin
          // Repeat code gets no special treatment here
          if (!state_ff.sel_on || state_ff.sel_code != state_ff.scan_idx) begin
            nxt_state.irq_inband = 1'b1;
          end
          nxt_state.sel_on = 1'b1;
          nxt_state.sel_code = state_ff.scan_idx;
          nxt_state.tone_status = '0;
          nxt_state.tone_status[TS_SEL_BIT] = 1'b1;
          nxt_state.tone_status[TS_CODE_LSB +: CODE_W] = state_ff.scan_idx;
          nxt_state.fsm = ST_IDLE;
        end else if (state_ff.scan_idx == CODE_W'(NCODES - 1)) begin
          // Last slot missed: no valid tone any more
          if (state_ff.sel_on) begin
            nxt_state.irq_inband = 1'b1;
            nxt_state.tone_status = '0;
          end
          nxt_state.sel_on = 1'b0;
          nxt_state.fsm = ST_IDLE;
        end else begin
          nxt_state.scan_idx = state_ff.scan_idx + 4'h1;
          nxt_state.fsm = ST_SCAN_RD;
        end
      end
      ST_BUS_RD: begin
        nxt_state.rdata = '0;
        if (read) begin
          if (address == OFS_STATUS) begin
            nxt_state.rdata[ST_INBAND_BIT] = state_ff.irq_inband;
            nxt_state.rdata[ST_DTMF_BIT] = state_ff.irq_dtmf;
          end else if (address == OFS_TONE) begin
            nxt_state.rdata[15:0] = state_ff.tone_status;
          end else if (address == OFS_MODE) begin
            nxt_state.rdata[15:0] = state_ff.mode;
          end else if (address == OFS_TXTONE) begin
            nxt_state.rdata[15:0] = state_ff.tx;
          end else if (is_slot(address)) begin
            nxt_state.rdata[FREQ_W-1:0] = mem_rdata;
          end
        end
        nxt_state.fsm = ST_BUS_ACK;
      end
      ST_BUS_ACK: begin
        nxt_state.fsm = ST_IDLE;
      end
    endcase

    // Inband tone dropped while reported
    if (state_ff.sel_on && !(sel_en && sel_tone_valid)) begin
      nxt_state.sel_on = 1'b0;
      nxt_state.irq_inband = 1'b1;
      nxt_state.tone_status = '0;
    end

    // DTMF: events only on on/off, a new key while on just updates status
    if (dtmf_en && dtmf_tone_valid && dtmf_hit[CODE_W]) begin
      if (!state_ff.dtmf_on) begin
        nxt_state.irq_dtmf = 1'b1;
      end
      nxt_state.dtmf_on = 1'b1;
      nxt_state.dtmf_code = dtmf_hit[CODE_W-1:0];
      nxt_state.tone_status = '0;
      nxt_state.tone_status[TS_DTMF_BIT] = 1'b1;
      nxt_state.tone_status[TS_CODE_LSB +: CODE_W] = dtmf_hit[CODE_W-1:0];
    end else if (state_ff.dtmf_on) begin
      nxt_state.dtmf_on = 1'b0;
      nxt_state.irq_dtmf = 1'b1;
      nxt_state.tone_status = '0;
    end

    // Tx pair from DTMF code in bits 3-0
    nxt_state.tx_lo = '0;
    nxt_state.tx_hi = '0;
    if (state_ff.tx[TX_GEN_BIT]) begin
      nxt_state.tx_lo = DTMF_LO[txc];
      nxt_state.tx_hi = DTMF_HI[txc];
      if (state_ff.tx[TX_SINGLE_BIT]) begin
        if (DTMF_SINGLE_HI[txc]) begin
          nxt_state.tx_lo = '0;
        end else begin
          nxt_state.tx_hi = '0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '{fsm: ST_IDLE, mode: MODE_RESET, tx: TX_RESET, default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs
  assign readdata = state_ff.rdata;
  assign waitrequest = !(state_ff.fsm == ST_BUS_ACK);
  assign tone_irq = state_ff.irq_inband || state_ff.irq_dtmf;
  assign tx_sel_code = state_ff.tx[TX_SEL_LSB +: CODE_W];
  assign tx_low_freq = state_ff.tx_lo;
  assign tx_high_freq = state_ff.tx_hi;

  // ==========================================================
  // Checks
  chk_inband_on_irq: assert property (@(posedge clk) disable iff (!nrst)
    $rose(state_ff.sel_on) |-> state_ff.irq_inband && tone_irq)
    else $error("inband tone start without event");

  chk_scan_first: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff.fsm == ST_SCAN_CMP && sel_en && sel_tone_valid && near(state_ff.cand, mem_rdata))
    |=> state_ff.sel_on && state_ff.sel_code == $past(state_ff.scan_idx)
        && state_ff.fsm == ST_IDLE)
    else $error("scan reported wrong code");

  chk_end_clears: assert property (@(posedge clk) disable iff (!nrst)
    ($fell(state_ff.sel_on) && !state_ff.dtmf_on) |-> state_ff.tone_status == 16'h0000)
    else $error("tone status not cleared at tone end");

  chk_sel_fields: assert property (@(posedge clk) disable iff (!nrst)
    $rose(state_ff.sel_on) && !state_ff.dtmf_on |->
      state_ff.tone_status[TS_SEL_BIT] && !state_ff.tone_status[TS_DTMF_BIT]
      && state_ff.tone_status[TS_CODE_LSB +: CODE_W] == state_ff.sel_code)
    else $error("selcall status fields wrong");

  chk_dtmf_event: assert property (@(posedge clk) disable iff (!nrst)
    $changed(state_ff.dtmf_on) |-> state_ff.irq_dtmf ##1 (state_ff.irq_dtmf || $past(ack && read)))
    else $error("dtmf edge without event");

  chk_dtmf_fields: assert property (@(posedge clk) disable iff (!nrst)
    $rose(state_ff.dtmf_on) |-> state_ff.tone_status[TS_DTMF_BIT]
      && !state_ff.tone_status[TS_SEL_BIT]
      && state_ff.tone_status[TS_CODE_LSB +: CODE_W] == state_ff.dtmf_code)
    else $error("dtmf status fields wrong");

  chk_single_tone: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff.tx[TX_GEN_BIT] && state_ff.tx[TX_SINGLE_BIT] && $stable(state_ff.tx))
    |=> (tx_low_freq == 12'h000) != (tx_high_freq == 12'h000))
    else $error("single tone sends both or neither");

  chk_read_clear: assert property (@(posedge clk) disable iff (!nrst)
    (ack && read && address == OFS_STATUS && state_ff.sel_on == nxt_state.sel_on
     && state_ff.dtmf_on == nxt_state.dtmf_on
     && state_ff.rdata[ST_INBAND_BIT] == state_ff.irq_inband
     && state_ff.rdata[ST_DTMF_BIT] == state_ff.irq_dtmf)
    |=> !tone_irq)
    else $error("status read did not clear events");

  chk_bus_answer: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff.fsm == ST_BUS_RD) |=> !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");
endmodule : inband_tone_decode_report

// [tb/tone_source_model.sv]
/*
  Tone detector stand-in that drives the block's detector inputs.
  Assumes the bench calls its tasks just after a rising clk edge.
*/
`timescale 1ns/100ps
module tone_source_model
  import tone_report_pkg::*;
(
  input wire logic clk,
  output logic sel_tone_valid,
  output logic [FREQ_W-1:0] sel_tone_freq,
  output logic dtmf_tone_valid,
  output logic [FREQ_W-1:0] dtmf_low_freq,
  output logic [FREQ_W-1:0] dtmf_high_freq
);
  // ==========================================================
  // Idle state
  initial begin
    sel_tone_valid = 1'b0;
    sel_tone_freq = 12'h000;
    dtmf_tone_valid = 1'b0;
    dtmf_low_freq = 12'h000;
    dtmf_high_freq = 12'h000;
  end
  // ==========================================================
  // Requests
  // A released line shows the inverse of its last value, so a stale
  // frequency can never pass for a match
  task automatic sel(input logic v, input logic [FREQ_W-1:0] f);
    sel_tone_valid <= v;
    sel_tone_freq <= v ? f : ~sel_tone_freq;
    @(posedge clk);
  endtask : sel
  task automatic dtmf(input logic v, input logic [FREQ_W-1:0] lo,
                      input logic [FREQ_W-1:0] hi);
    dtmf_tone_valid <= v;
    dtmf_low_freq <= v ? lo : ~dtmf_low_freq;
    dtmf_high_freq <= v ? hi : ~dtmf_high_freq;
    @(posedge clk);
  endtask : dtmf
endmodule : tone_source_model

// [tb/inband_tone_decode_report_tb_top.sv]
/*
  Self-checking bench: Avalon-MM host tasks plus tone scenarios.
  Assumes the detector model answers at once and host reads follow irq.
*/
`timescale 1ns/100ps
module inband_tone_decode_report_tb_top
  import tone_report_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest, tone_irq, sel_tone_valid, dtmf_tone_valid;
  logic [CODE_W-1:0] tx_sel_code;
  logic [FREQ_W-1:0] tx_low_freq, tx_high_freq, sel_tone_freq;
  logic [FREQ_W-1:0] dtmf_low_freq, dtmf_high_freq;
  logic [31:0] q;
  int n_mismatch = 0;
  int checks = 0;
  // Key pad pairs per code 0..f: 941/697/770/852 low, 1209..1633 high
  logic [11:0] lo_hz [16] = '{12'h3ad, 12'h2b9, 12'h2b9, 12'h2b9, 12'h302,
    12'h302, 12'h302, 12'h354, 12'h354, 12'h354, 12'h3ad, 12'h3ad, 12'h3ad,
    12'h2b9, 12'h302, 12'h354};
  logic [11:0] hi_hz [16] = '{12'h661, 12'h4b9, 12'h538, 12'h5c5, 12'h4b9,
    12'h538, 12'h5c5, 12'h4b9, 12'h538, 12'h5c5, 12'h538, 12'h4b9, 12'h5c5,
    12'h661, 12'h661, 12'h661};

  // ==========================================================
  // Clock, parts
  initial begin
    forever #10 clk = ~clk;
  end
  inband_tone_decode_report u_inband_tone_decode_report (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sel_tone_valid(sel_tone_valid),
    .sel_tone_freq(sel_tone_freq), .dtmf_tone_valid(dtmf_tone_valid),
    .dtmf_low_freq(dtmf_low_freq), .dtmf_high_freq(dtmf_high_freq),
    .tone_irq(tone_irq), .tx_sel_code(tx_sel_code),
    .tx_low_freq(tx_low_freq), .tx_high_freq(tx_high_freq));
  tone_source_model u_tone_source_model (
    .clk(clk), .sel_tone_valid(sel_tone_valid), .sel_tone_freq(sel_tone_freq),
    .dtmf_tone_valid(dtmf_tone_valid), .dtmf_low_freq(dtmf_low_freq),
    .dtmf_high_freq(dtmf_high_freq));

  // ==========================================================
  // Tasks
  task automatic tally_and_finish;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Request holds until waitrequest is sampled low; one idle edge follows
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 200);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 200) n_mismatch++;
    @(posedge clk);
  endtask : bus
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask : rd_chk
  // Host side: wait for irq, then status and tone status are read
  task automatic evt(input logic [31:0] st, input logic [31:0] tn);
    int n;
    n = 0;
    while (tone_irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("irq", {31'h0, tone_irq}, 32'h1);
    rd_chk("status", OFS_STATUS, st);
    check("irq_cleared", {31'h0, tone_irq}, 32'h0);
    rd_chk("tone", OFS_TONE, tn);
  endtask : evt

  // ==========================================================
  // Watchdog and tests
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk("status_rst", OFS_STATUS, 32'h0);
    rd_chk("tone_rst", OFS_TONE, 32'h0);
    rd_chk("mode_rst", OFS_MODE, 32'h0);
    rd_chk("tx_rst", OFS_TXTONE, 32'h0);
    rd_chk("slot_code0", 8'h48, 32'h7bd);
    rd_chk("slot_code15", 8'h84, 32'h41f);
    rd_chk("unmapped", 8'h20, 32'h0);
    // Both detectors on together; the host still sees clean reports
    bus(1'b1, OFS_MODE, 32'h3);
    u_tone_source_model.sel(1'b1, 12'h7bd);
    evt(32'h2000, 32'h8000);
    u_tone_source_model.sel(1'b1, 12'h83e);
    evt(32'h2000, 32'hf000);
    // Code 5 now shares 2110 Hz with code 14; the lower code must win
    bus(1'b1, 8'h5c, 32'h83e);
    rd_chk("slot_code5", 8'h5c, 32'h83e);
    u_tone_source_model.sel(1'b1, 12'h464);
    evt(32'h2000, 32'h8800);
    u_tone_source_model.sel(1'b1, 12'h83e);
    evt(32'h2000, 32'ha800);
    u_tone_source_model.sel(1'b0, 12'h000);
    evt(32'h2000, 32'h0);
    for (int c = 0; c < 16; c++) begin
      u_tone_source_model.dtmf(1'b1, lo_hz[c], hi_hz[c]);
      evt(32'h1000, {17'h0, c[3:0], 11'h400});
      u_tone_source_model.dtmf(1'b0, 12'h000, 12'h000);
      evt(32'h1000, 32'h0);
    end
    // DTMF detector switched off: a key pair must raise nothing
    bus(1'b1, OFS_MODE, 32'h1);
    u_tone_source_model.dtmf(1'b1, lo_hz[5], hi_hz[5]);
    repeat (4) @(posedge clk);
    check("dtmf_masked", {31'h0, tone_irq}, 32'h0);
    rd_chk("tone_masked", OFS_TONE, 32'h0);
    u_tone_source_model.dtmf(1'b0, 12'h000, 12'h000);
    // Voice muting stays with the host; this block has no audio path
    // Host sends 3, repeat, 3 for a doubled digit
    foreach (lo_hz[i]) begin
      if (i < 3) begin
        bus(1'b1, OFS_TXTONE, {17'h0, (i == 1) ? REPEAT_CODE : 4'h3, 11'h0});
        check("tx_sel", {28'h0, tx_sel_code}, (i == 1) ? 32'he : 32'h3);
      end
    end
    bus(1'b1, OFS_TXTONE, 32'h4815);
    rd_chk("tx_reg", OFS_TXTONE, 32'h4815);
    check("tx_sel", {28'h0, tx_sel_code}, 32'h9);
    check("tx_lo", {20'h0, tx_low_freq}, 32'h302);
    check("tx_hi", {20'h0, tx_high_freq}, 32'h538);
    bus(1'b1, OFS_TXTONE, 32'h0035);
    // Tx pair is registered one cycle after the register write
    @(posedge clk);
    check("single_lo", {20'h0, tx_low_freq}, 32'h302);
    check("single_hi", {20'h0, tx_high_freq}, 32'h0);
    bus(1'b1, OFS_TXTONE, 32'h003d);
    @(posedge clk);
    check("single_lo", {20'h0, tx_low_freq}, 32'h0);
    check("single_hi", {20'h0, tx_high_freq}, 32'h661);
    tally_and_finish;
  end
endmodule : inband_tone_decode_report_tb_top
